// >>> core/pbfs_pkg.sv
/*
  Constants, types and register map of the port B function select block.
  Assumes a 32-bit APB slave with 12-bit byte address inside the block window.
*/
package pbfs_pkg;
    localparam int          PBFS_PINS      = 10;
    localparam int          PBFS_AW        = 12;
    // printed offsets are not all word aligned: they are register indices
    localparam logic [31:0] PBFS_IDX_DIR   = 32'hffff8394;
    localparam logic [31:0] PBFS_IDX_HI    = 32'hffff8398;
    localparam logic [31:0] PBFS_IDX_LO    = 32'hffff839a;
    localparam logic [15:0] PBFS_RST       = 16'h0000;
    localparam logic [15:0] PBFS_HI_MASK   = 16'h000f;
    localparam logic [15:0] PBFS_LO_MASK   = 16'hfff5;
    localparam logic [15:0] PBFS_DIR_MASK  = 16'h03ff;
    localparam logic [15:0] PBFS_SMALL_LO  = 16'hfff0;
    localparam logic [15:0] PBFS_SMALL_DIR = 16'h03fc;
    localparam int          PBFS_NARROW    = 2;
    // per pin: lsb of its field, and whether it sits in the high register
    localparam int          PBFS_FLD_LSB [PBFS_PINS] = '{0, 2, 4, 6, 8, 10, 12, 14, 0, 2};
    localparam logic [9:0]  PBFS_IN_HI     = 10'h300;
    // interrupt number and address line (minus 16) per pin; 15 means none
    localparam int          PBFS_NONE      = 15;
    localparam int          PBFS_IRQ_NUM [PBFS_PINS] = '{15, 15, 0, 1, 2, 3, 15, 15, 6, 7};
    localparam int          PBFS_ADR_NUM [PBFS_PINS] = '{0, 1, 15, 15, 15, 15, 2, 3, 4, 5};
    localparam logic [1:0]  PBFS_C_IRQ     = 2'h1;
    localparam logic [1:0]  PBFS_C_ADDR    = 2'h2;
    localparam logic [1:0]  PBFS_C_STRB    = 2'h3;

    typedef enum logic [2:0] {
        PBFS_GPIO, PBFS_IRQ, PBFS_ADDR, PBFS_BUS_READ_WRITE_OUT, PBFS_COLH, PBFS_COLL, PBFS_RAS, PBFS_WAIT
    } pbfs_func_t;

    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
        logic [15:0] dir;
    } pbfs_ctrl_t;

    typedef struct packed {
        logic [7:0] irq_en;
        logic [5:0] addr_en;
        logic       bus_read_write_out_en;
        logic       colh_en;
        logic       coll_en;
        logic       ras_en;
        logic       wait_en;
    } pbfs_ext_t;
endpackage

// >>> core/pbfs_port_b.sv
/*
  Port B pin function select and direction registers behind an APB slave.
  Assumes mode inputs are synchronous to pclk and stable in normal use.
*/
`timescale 1ns/10ps
// How it works
// - pin 9 field selects gpio, interrupt 7, address 21; code 11 reserved.
// - pin 8 field selects gpio, interrupt 6, address 20 or wait input.
// - pin 7 field selects gpio or address 19; other codes reserved.
// - pin 6 field selects gpio or address 18; other codes reserved.
// - pin 5 field selects gpio, interrupt 3 or read/write output.
// - pin 4 field selects gpio, interrupt 2 or upper column strobe.
// - pin 3 field selects gpio, interrupt 1 or lower column strobe.
// - pin 2 field selects gpio, interrupt 0 or row strobe.
// - pin 1 bit selects gpio or address 17.
// - pin 0 bit selects gpio or address 16.
// - with on-chip rom disabled, pins 1 and 0 drive address 17 and 16 whatever their bits, except in single-chip mode or the small variant.
// - single-chip mode turns every external-bus selection back into gpio.
// - reset clears all fields and direction bits, so all pins start gpio, except pins 1 and 0 when rom disabled forces them to address.
// - small variant treats pin 1 and pin 0 bits as reserved.
module pbfs_port_b
    import pbfs_pkg::*;
#(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PBFS_AW-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               mode_single_chip,
    input  wire logic               mode_rom_disabled,
    output pbfs_func_t [9:0]        pin_func,
    output logic [9:0]              gpio_output_en,
    output pbfs_ext_t               ext_sel
);

    localparam logic [15:0] LO_WMASK  = SMALL_VARIANT ? PBFS_SMALL_LO : PBFS_LO_MASK;
    localparam logic [15:0] DIR_WMASK = SMALL_VARIANT ? PBFS_SMALL_DIR : PBFS_DIR_MASK;

    pbfs_ctrl_t       ctrl;
    pbfs_func_t [9:0] next_func;
    pbfs_ext_t        next_ext;
    logic [9:0]       next_oe;
    logic             setup;
    logic             access;
    logic [2:0]       sel;
    logic [15:0]      lane_mask;

    function automatic logic hit(input logic [PBFS_AW-1:0] a, input logic [31:0] idx);
        hit = (a[PBFS_AW-1:2] == idx[PBFS_AW-3:0]) && (a[1:0] == 2'h0);
    endfunction

    function automatic pbfs_func_t decode(input int pin, input logic [1:0] code,
                                          input logic single, input logic romdis);
        pbfs_func_t f;
        f = PBFS_GPIO;
        unique case (pin)
            9, 8: begin
                if (code == PBFS_C_IRQ) f = PBFS_IRQ;
                if (code == PBFS_C_ADDR) f = PBFS_ADDR;
                if (pin == 8 && code == PBFS_C_STRB) f = PBFS_WAIT;
            end
            7, 6: begin
                if (code == PBFS_C_ADDR) f = PBFS_ADDR;
            end
            5, 4, 3, 2: begin
                if (code == PBFS_C_IRQ) f = PBFS_IRQ;
                if (code == PBFS_C_STRB) begin
                    unique case (pin)
                        5: f = PBFS_BUS_READ_WRITE_OUT;
                        4: f = PBFS_COLH;
                        3: f = PBFS_COLL;
                        default: f = PBFS_RAS;
                    endcase
                end
            end
            default: begin
                if (code[0] || romdis) f = PBFS_ADDR;
                if (SMALL_VARIANT) f = PBFS_GPIO;
            end
        endcase
        // interrupt inputs are not bus functions, so they survive single-chip mode
        if (single && f != PBFS_IRQ) f = PBFS_GPIO;
        decode = f;
    endfunction

    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign pready  = 1'b1;
    assign sel     = {hit(paddr, PBFS_IDX_DIR), hit(paddr, PBFS_IDX_HI), hit(paddr, PBFS_IDX_LO)};
    assign pslverr = access && (sel == 3'h0);
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // register writes land at the access edge; reserved bits never store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '{hi: PBFS_RST, lo: PBFS_RST, dir: PBFS_RST};
        end else if (access && pwrite) begin
            if (sel[1])
                ctrl.hi <= (ctrl.hi & ~(lane_mask & PBFS_HI_MASK))
                         | (pwdata[15:0] & lane_mask & PBFS_HI_MASK);
            if (sel[0])
                ctrl.lo <= (ctrl.lo & ~(lane_mask & LO_WMASK))
                         | (pwdata[15:0] & lane_mask & LO_WMASK);
            if (sel[2])
                ctrl.dir <= (ctrl.dir & ~(lane_mask & DIR_WMASK))
                          | (pwdata[15:0] & lane_mask & DIR_WMASK);
        end
    end

    // read data is captured in the setup cycle so the answer needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= 32'h0000_0000;
            unique case (1'b1)
                sel[2]: prdata[15:0] <= ctrl.dir;
                sel[1]: prdata[15:0] <= ctrl.hi;
                sel[0]: prdata[15:0] <= ctrl.lo;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        next_ext = '0;
        next_oe  = '0;
        for (int p = 0; p < PBFS_PINS; p++) begin
            logic [1:0] code;
            code = PBFS_IN_HI[p] ? ctrl.hi[PBFS_FLD_LSB[p] +: 2] : ctrl.lo[PBFS_FLD_LSB[p] +: 2];
            if (p < PBFS_NARROW) code = {1'b0, code[0]};
            next_func[p] = decode(p, code, mode_single_chip, mode_rom_disabled);
            next_oe[p] = ctrl.dir[p] && next_func[p] == PBFS_GPIO;
            if (next_func[p] == PBFS_IRQ && PBFS_IRQ_NUM[p] != PBFS_NONE)
                next_ext.irq_en[PBFS_IRQ_NUM[p][2:0]] = 1'b1;
            if (next_func[p] == PBFS_ADDR && PBFS_ADR_NUM[p] != PBFS_NONE)
                next_ext.addr_en[PBFS_ADR_NUM[p][2:0]] = 1'b1;
            if (next_func[p] == PBFS_BUS_READ_WRITE_OUT) next_ext.bus_read_write_out_en = 1'b1;
            if (next_func[p] == PBFS_COLH) next_ext.colh_en = 1'b1;
            if (next_func[p] == PBFS_COLL) next_ext.coll_en = 1'b1;
            if (next_func[p] == PBFS_RAS) next_ext.ras_en = 1'b1;
            if (next_func[p] == PBFS_WAIT) next_ext.wait_en = 1'b1;
        end
    end

    // pin controls are registered: one cycle behind a register write or mode change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_func       <= '{default: PBFS_GPIO};
            gpio_output_en <= '0;
            ext_sel        <= '0;
        end else begin
            pin_func       <= next_func;
            gpio_output_en <= next_oe;
            ext_sel        <= next_ext;
        end
    end

    // registered pin view, used to check the output enable against the direction bits
    logic [9:0] func_is_gpio;
    always_comb begin
        func_is_gpio = '0;
        for (int p = 0; p < PBFS_PINS; p++) begin
            func_is_gpio[p] = (pin_func[p] == PBFS_GPIO);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_hi_reserved_zero: assert property ((ctrl.hi & ~PBFS_HI_MASK) == '0 &&
        (ctrl.lo & ~LO_WMASK) == '0 && (ctrl.dir & ~DIR_WMASK) == '0)
        else $error("reserved control bit is set");
    chk_pin9_irq_route: assert property (ctrl.hi[3:2] == PBFS_C_IRQ |=> ext_sel.irq_en[7])
        else $error("pin 9 interrupt not routed");
    chk_pin8_wait_route: assert property (
        ctrl.hi[1:0] == PBFS_C_STRB && !mode_single_chip |=> ext_sel.wait_en)
        else $error("pin 8 wait input not routed");
    chk_pin7_addr_route: assert property (
        ctrl.lo[15:14] == PBFS_C_ADDR && !mode_single_chip |=> ext_sel.addr_en[3])
        else $error("pin 7 address not routed");
    chk_pin6_reserved_gpio: assert property (ctrl.lo[13:12] == PBFS_C_STRB
        |=> pin_func[6] == PBFS_GPIO)
        else $error("pin 6 reserved code not gpio");
    chk_pin5_bus_read_write_out_route: assert property (
        ctrl.lo[11:10] == PBFS_C_STRB && !mode_single_chip |=> ext_sel.bus_read_write_out_en)
        else $error("pin 5 read/write not routed");
    chk_pin4_colh_route: assert property (
        ctrl.lo[9:8] == PBFS_C_STRB && !mode_single_chip |=> ext_sel.colh_en)
        else $error("pin 4 upper column strobe not routed");
    chk_pin3_irq_route: assert property (ctrl.lo[7:6] == PBFS_C_IRQ |=> ext_sel.irq_en[1])
        else $error("pin 3 interrupt not routed");
    chk_pin2_ras_route: assert property (
        ctrl.lo[5:4] == PBFS_C_STRB && !mode_single_chip |=> ext_sel.ras_en)
        else $error("pin 2 row strobe not routed");
    chk_pin1_addr_route: assert property (
        !SMALL_VARIANT && ctrl.lo[2] && !mode_single_chip |=> ext_sel.addr_en[1])
        else $error("pin 1 address not routed");
    chk_pin0_addr_route: assert property (
        !SMALL_VARIANT && ctrl.lo[0] && !mode_single_chip |=> ext_sel.addr_en[0])
        else $error("pin 0 address not routed");
    chk_romdis_addr_force: assert property (
        !SMALL_VARIANT && mode_rom_disabled && !mode_single_chip |=> ext_sel.addr_en[1:0] == 2'h3)
        else $error("rom disabled mode did not force address pins");
    chk_single_no_bus: assert property (mode_single_chip |=> ext_sel.addr_en == '0 &&
        !ext_sel.bus_read_write_out_en && !ext_sel.colh_en && !ext_sel.coll_en && !ext_sel.ras_en &&
        !ext_sel.wait_en)
        else $error("bus function active in single-chip mode");
    chk_reset_all_gpio: assert property (disable iff (1'b0)
        $rose(presetn) |-> ctrl == '0 && gpio_output_en == '0 && ext_sel == '0)
        else $error("state not cleared by reset");
    chk_small_pins_quiet: assert property (SMALL_VARIANT |-> ctrl.dir[1:0] == 2'h0 &&
        ctrl.lo[2] == 1'b0 && ctrl.lo[0] == 1'b0)
        else $error("small variant stored reserved pin bits");
    chk_dir_drives_oe: assert property (
        gpio_output_en == ($past(ctrl.dir[9:0]) & func_is_gpio))
        else $error("gpio output enable differs from direction");
    chk_pin9_addr_route: assert property (
        ctrl.hi[3:2] == PBFS_C_ADDR && !mode_single_chip |=> ext_sel.addr_en[5])
        else $error("pin 9 address not routed");
    chk_pin9_reserved_gpio: assert property (
        ctrl.hi[3:2] == PBFS_C_STRB |=> pin_func[9] == PBFS_GPIO)
        else $error("pin 9 reserved code not gpio");
    chk_pin8_irq_route: assert property (
        ctrl.hi[1:0] == PBFS_C_IRQ |=> ext_sel.irq_en[6])
        else $error("pin 8 interrupt not routed");
    chk_pin8_addr_route: assert property (
        ctrl.hi[1:0] == PBFS_C_ADDR && !mode_single_chip |=> ext_sel.addr_en[4])
        else $error("pin 8 address not routed");
    chk_pin7_reserved_gpio: assert property (
        ctrl.lo[15:14] == PBFS_C_IRQ || ctrl.lo[15:14] == PBFS_C_STRB
        |=> pin_func[7] == PBFS_GPIO)
        else $error("pin 7 reserved code not gpio");
    chk_pin6_addr_route: assert property (
        ctrl.lo[13:12] == PBFS_C_ADDR && !mode_single_chip |=> ext_sel.addr_en[2])
        else $error("pin 6 address not routed");
    chk_pin5_irq_route: assert property (
        ctrl.lo[11:10] == PBFS_C_IRQ |=> ext_sel.irq_en[3])
        else $error("pin 5 interrupt not routed");
    chk_pin5_reserved_gpio: assert property (
        ctrl.lo[11:10] == PBFS_C_ADDR |=> pin_func[5] == PBFS_GPIO)
        else $error("pin 5 reserved code not gpio");
    chk_pin4_irq_route: assert property (
        ctrl.lo[9:8] == PBFS_C_IRQ |=> ext_sel.irq_en[2])
        else $error("pin 4 interrupt not routed");
    chk_pin3_coll_route: assert property (
        ctrl.lo[7:6] == PBFS_C_STRB && !mode_single_chip |=> ext_sel.coll_en)
        else $error("pin 3 lower column strobe not routed");
    chk_pin2_irq_route: assert property (
        ctrl.lo[5:4] == PBFS_C_IRQ |=> ext_sel.irq_en[0])
        else $error("pin 2 interrupt not routed");
    chk_pin1_gpio_default: assert property (
        !ctrl.lo[2] && !mode_rom_disabled |=> pin_func[1] == PBFS_GPIO)
        else $error("pin 1 not gpio with clear bit");
    chk_pin0_gpio_default: assert property (
        !ctrl.lo[0] && !mode_rom_disabled |=> pin_func[0] == PBFS_GPIO)
        else $error("pin 0 not gpio with clear bit");
    chk_single_keeps_irq: assert property (
        mode_single_chip && ctrl.lo[5:4] == PBFS_C_IRQ |=> pin_func[2] == PBFS_IRQ)
        else $error("interrupt input lost in single-chip mode");
    chk_small_pins_gpio: assert property (
        SMALL_VARIANT |=> pin_func[1] == PBFS_GPIO && pin_func[0] == PBFS_GPIO &&
        gpio_output_en[1:0] == 2'h0)
        else $error("small variant drives reserved pins");

    cov_write_hi: cover property (access && pwrite && sel[1]);
    cov_rom_force: cover property (mode_rom_disabled && !mode_single_chip && ctrl.lo == '0);
    cov_wait_sel: cover property (ext_sel.wait_en);
    cov_single_override: cover property (mode_single_chip && ctrl.lo[15:14] == PBFS_C_ADDR);
    cov_unmapped: cover property (pslverr);

endmodule

// >>> testbench/pbfs_board.sv
/*
  Board-side model of the port B pins: marks which pins the board drives.
  Assumes pin_func and gpio_output_en come straight from the port B block.
*/
`timescale 1ns/10ps
module pbfs_board
    import pbfs_pkg::*;
(
    input  wire pbfs_func_t [9:0] pin_func,
    input  wire logic [9:0]       gpio_output_en,
    output logic [9:0]            board_drv
);
    // the board drives request inputs, the wait input and gpio inputs only
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            board_drv[i] = (pin_func[i] == PBFS_IRQ) || (pin_func[i] == PBFS_WAIT) ||
                ((pin_func[i] == PBFS_GPIO) && !gpio_output_en[i]);
        end
    end
endmodule

// >>> testbench/tb_pbfs_port_b.sv
/*
  Self-checking bench for the port B function select block.
  Assumes a zero or more wait state APB slave and level mode inputs.
*/
`timescale 1ns/10ps
module tb_pbfs_port_b;
    import pbfs_pkg::*;
    logic             pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]      paddr = '0;
    logic [31:0]      pwdata = '0;
    logic [3:0]       pstrb = 4'hf;
    logic             sc = 0, rd = 0;
    logic [31:0]      prdata, prdata_s, rs;
    logic             pready, pslverr, pready_s, pslverr_s;
    pbfs_func_t [9:0] pin_func, func_s;
    logic [9:0]       oen, oen_s, board_drv;
    pbfs_ext_t        ext, ext_s;
    int               fails = 0, num_checks = 0;
    localparam pbfs_func_t STRB [10] = '{PBFS_GPIO, PBFS_GPIO, PBFS_RAS, PBFS_COLL,
        PBFS_COLH, PBFS_BUS_READ_WRITE_OUT, PBFS_GPIO, PBFS_GPIO, PBFS_WAIT, PBFS_GPIO};

    always #10 pclk = ~pclk;

    pbfs_port_b DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .mode_single_chip(sc), .mode_rom_disabled(rd),
        .pin_func, .gpio_output_en(oen), .ext_sel(ext));
    // the small variant shares the bus but answers on its own outputs
    pbfs_port_b #(.SMALL_VARIANT(1'b1)) DUT_S (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s),
        .mode_single_chip(sc), .mode_rom_disabled(rd), .pin_func(func_s),
        .gpio_output_en(oen_s), .ext_sel(ext_s));
    pbfs_board BOARD (.pin_func, .gpio_output_en(oen), .board_drv);

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            wrap_up();
        end
        r = prdata;
        e = pslverr;
        rs = prdata_s;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, s, r, e);
    endtask

    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] x,
                        input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 16'h0, 4'h0, r, e);
        chk(what, x, r);
        chk({what, " slverr"}, {31'h0, xe}, {31'h0, e});
    endtask

    function automatic pbfs_func_t fexp(int p, logic [1:0] c, logic s, logic r);
        pbfs_func_t f;
        f = PBFS_GPIO;
        if (p < 2) f = (c[0] || (r && !s)) ? PBFS_ADDR : PBFS_GPIO;
        else if (c == 2'h1 && p != 6 && p != 7) f = PBFS_IRQ;
        else if (c == 2'h2 && p > 5) f = PBFS_ADDR;
        else if (c == 2'h3) f = STRB[p];
        if (s && f != PBFS_IRQ) f = PBFS_GPIO;
        return f;
    endfunction

    initial begin
        logic [1:0]  c;
        logic [15:0] dv;
        pbfs_ext_t   e;
        pbfs_func_t  f;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        rchk("dir reset", 12'he50, 32'h0, 1'b0);
        rchk("hi reset", 12'he60, 32'h0, 1'b0);
        rchk("lo reset", 12'he68, 32'h0, 1'b0);
        chk("oen reset", 32'h0, {22'h0, oen});
        wr(12'he50, 16'hffff);
        wr(12'he60, 16'hffff);
        wr(12'he68, 16'hffff);
        rchk("dir mask", 12'he50, 32'h3ff, 1'b0);
        chk("small dir", 32'h3fc, rs);
        rchk("hi mask", 12'he60, 32'hf, 1'b0);
        rchk("lo mask", 12'he68, 32'hfff5, 1'b0);
        chk("small lo", 32'hfff0, rs);
        rchk("unmapped", 12'h004, 32'h0, 1'b1);
        wr(12'he68, 16'h0000);
        wr(12'he68, 16'hffff, 4'h1);
        rchk("lane", 12'he68, 32'hf5, 1'b0);
        // every code of every field under all four mode combinations
        for (int k = 0; k < 16; k++) begin
            c = k[1:0];
            sc <= k[2];
            rd <= k[3];
            dv = k[0] ? 16'h0155 : 16'h02aa;
            wr(12'he68, {8{c}});
            wr(12'he60, {8{c}});
            wr(12'he50, dv);
            repeat (2) @(posedge pclk);
            e = '0;
            for (int p = 0; p < 10; p++) begin
                f = fexp(p, c, k[2], k[3]);
                chk($sformatf("func pin %0d case %0d", p, k), f, pin_func[p]);
                chk($sformatf("oen pin %0d case %0d", p, k), dv[p] && f == PBFS_GPIO,
                    oen[p]);
                if (f == PBFS_IRQ) e.irq_en[PBFS_IRQ_NUM[p]] = 1'b1;
                if (f == PBFS_ADDR) e.addr_en[PBFS_ADR_NUM[p]] = 1'b1;
                {e.bus_read_write_out_en, e.colh_en, e.coll_en, e.ras_en, e.wait_en} =
                    {e.bus_read_write_out_en, e.colh_en, e.coll_en, e.ras_en, e.wait_en} |
                    {f == PBFS_BUS_READ_WRITE_OUT, f == PBFS_COLH, f == PBFS_COLL, f == PBFS_RAS, f == PBFS_WAIT};
            end
            chk($sformatf("ext case %0d", k), e, ext);
            chk("small pin0", PBFS_GPIO, func_s[0]);
            chk("contention", 32'h0, {22'h0, board_drv & oen});
        end
        wrap_up();
    end
endmodule
